/* rvag_pkg.sv */
// package: vector numbering, address widths and carrier types for the vector generator
package rvag_pkg;
  localparam int RVAG_ADDR_W = 12;
  localparam int RVAG_NUM_REQ = 25;
  localparam int RVAG_IDX_W = 5;
  localparam logic [11:0] RVAG_RESET_OFFSET = 12'h000;
  localparam logic [11:0] RVAG_TABLE_START = 12'h001;
  localparam logic [11:0] RVAG_BOOT_RESET_DEFAULT = 12'hc00;
  localparam logic RVAG_FUSE_UNPROGRAMMED = 1'b1;
  // request index = vector offset - 1
  localparam logic [4:0] RVAG_IDX_EXT_A = 5'h00;
  localparam logic [4:0] RVAG_IDX_EXT_B = 5'h01;
  localparam logic [4:0] RVAG_IDX_PIN_CHANGE_A = 5'h02;
  localparam logic [4:0] RVAG_IDX_PIN_CHANGE_C = 5'h04;
  localparam logic [4:0] RVAG_IDX_WATCHDOG = 5'h05;
  localparam logic [4:0] RVAG_IDX_ASYNC_MATCH_A = 5'h06;
  localparam logic [4:0] RVAG_IDX_ASYNC_OVERFLOW = 5'h08;
  localparam logic [4:0] RVAG_IDX_WIDE_CAPTURE = 5'h09;
  localparam logic [4:0] RVAG_IDX_WIDE_OVERFLOW = 5'h0c;
  localparam logic [4:0] RVAG_IDX_BASIC_MATCH_A = 5'h0d;
  localparam logic [4:0] RVAG_IDX_BASIC_OVERFLOW = 5'h0f;
  localparam logic [4:0] RVAG_IDX_SPI_DONE = 5'h10;
  localparam logic [4:0] RVAG_IDX_USART_RX = 5'h11;
  localparam logic [4:0] RVAG_IDX_TX_BUFFER_EMPTY = 5'h12;
  localparam logic [4:0] RVAG_IDX_USART_TX = 5'h13;
  localparam logic [4:0] RVAG_IDX_CONVERTER = 5'h14;
  localparam logic [4:0] RVAG_IDX_NV_DATA_READY = 5'h15;
  localparam logic [4:0] RVAG_IDX_COMPARATOR = 5'h16;
  localparam logic [4:0] RVAG_IDX_TWO_WIRE = 5'h17;
  localparam logic [4:0] RVAG_IDX_PROGRAM_STORE_READY = 5'h18;

  typedef struct packed {
    logic ext_pin_request_a;
    logic ext_pin_request_b;
    logic pin_change_group_a;
    logic pin_change_group_b;
    logic pin_change_group_c;
    logic watchdog_timeout_request;
    logic async_counter_match_a;
    logic async_counter_match_b;
    logic async_counter_overflow;
    logic wide_counter_capture;
    logic wide_counter_match_a;
    logic wide_counter_match_b;
    logic wide_counter_overflow;
    logic basic_counter_match_a;
    logic basic_counter_match_b;
    logic basic_counter_overflow;
    logic spi_transfer_done;
    logic usart_rx_done;
    logic tx_buffer_empty;
    logic usart_tx_done;
    logic converter_done;
    logic nv_data_ready;
    logic comparator_event;
    logic two_wire_event;
    logic program_store_ready;
  } rvag_req_t;

  typedef struct packed {
    logic valid;
    logic is_reset;
    logic [4:0] vector_index;
    logic [11:0] address;
  } rvag_fetch_t;
endpackage

/* rvag_prio_enc.sv */
// lowest-index-first priority encoder over pending requests
`timescale 1ns/10ps
module rvag_prio_enc #(
  parameter int N = 25,
  parameter int W = 5
) (
  input wire logic [N-1:0] pending,
  output logic any,
  output logic [W-1:0] index
);
  always_comb begin
    any = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        any = 1'b1;
        index = W'(i);
      end
    end
  end
endmodule

/* rvag_vector_gen.sv */
// reset fetch address and interrupt vector address generator
`timescale 1ns/10ps
// What this block does
// - any reset cause steers the fetch to vector 1, address 0x000 by default
// - first external pin request uses offset 0x001, second uses 0x002
// - pin-change groups use 0x003 to 0x005; watchdog time-out uses 0x006
// - async 8-bit counter: match A 0x007, match B 0x008, overflow 0x009
// - 16-bit counter: capture 0x00A, match A 0x00B, B 0x00C, overflow 0x00D
// - other 8-bit counter: match A 0x00E, match B 0x00F, overflow 0x010
// - spi 0x011, usart receive 0x012, buffer empty 0x013, transmit 0x014
// - conversion complete uses 0x015, nonvolatile data ready uses 0x016
// - comparator 0x017, two-wire 0x018, program store ready 0x019, the last
// - programmed boot fuse starts execution at the boot loader address
// - relocation bit set adds boot section start to each interrupt vector offset
// - fuse 1 gives reset 0x000; table starts 0x001 or boot address plus 0x001
module rvag_vector_gen
  import rvag_pkg::*;
#(
  parameter logic [RVAG_ADDR_W-1:0] BOOT_RESET_ADDR = RVAG_BOOT_RESET_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_reset_pin,
  input wire logic power_on_detect,
  input wire logic brown_out_detect,
  input wire logic watchdog_system_reset,
  input wire logic boot_reset_select_fuse,
  input wire logic vector_relocate_select,
  input wire logic global_enable,
  input wire rvag_req_t request,
  input wire rvag_req_t request_enable,
  input wire logic fetch_ack,
  output rvag_fetch_t fetch
);
  typedef enum logic [1:0] {
    RVAG_IDLE = 2'b01,
    RVAG_HOLD = 2'b10
  } rvag_state_t;

  rvag_state_t state;
  rvag_state_t next_state;
  rvag_fetch_t next_fetch;
  logic [2:0] pin_sync1;
  logic [2:0] pin_sync2;
  logic reset_pending;
  logic fuse_latched;
  logic fuse_sync1;
  logic fuse_sync2;

  wire logic [RVAG_NUM_REQ-1:0] pending;
  wire logic req_any;
  wire logic [RVAG_IDX_W-1:0] req_index;
  wire logic reset_cause;
  wire logic [RVAG_ADDR_W-1:0] reset_address;
  wire logic [RVAG_ADDR_W-1:0] table_base;
  wire logic [RVAG_ADDR_W-1:0] vector_address;
  wire logic [2:0] pin_cause;
  wire logic in_idle;
  wire logic in_hold;
  wire logic take_reset;
  wire logic take_irq;
  wire logic abort_irq;
  wire logic accept;
  wire logic clear_reset_pending;
  wire logic [RVAG_IDX_W-1:0] irq_number;
  wire rvag_fetch_t reset_word;
  wire rvag_fetch_t irq_word;

  // the struct field order already matches vector order, so bit reversal gives index 0 first
  function automatic logic [RVAG_NUM_REQ-1:0] rvag_order(input rvag_req_t r);
    logic [RVAG_NUM_REQ-1:0] flat;
    logic [RVAG_NUM_REQ-1:0] out;
    flat = r;
    for (int i = 0; i < RVAG_NUM_REQ; i++) begin
      out[i] = flat[RVAG_NUM_REQ-1-i];
    end
    return out;
  endfunction

  // index n maps to table start plus n, covering 0x001..0x019 when the table is not relocated
  function automatic logic [RVAG_ADDR_W-1:0] rvag_vec_addr(
    input logic [RVAG_ADDR_W-1:0] base,
    input logic [RVAG_IDX_W-1:0] idx
  );
    return RVAG_ADDR_W'(base + {{(RVAG_ADDR_W-RVAG_IDX_W){1'b0}}, idx});
  endfunction

  assign pending = global_enable ? (rvag_order(request) & rvag_order(request_enable)) : '0;

  rvag_prio_enc #(
    .N(RVAG_NUM_REQ),
    .W(RVAG_IDX_W)
  ) u_prio (
    .pending(pending),
    .any(req_any),
    .index(req_index)
  );

  // external reset pin, power-on and brown-out, after their two-flop synchroniser
  assign pin_cause = pin_sync2;
  assign reset_cause = (|pin_cause) | watchdog_system_reset;
  assign reset_address = (fuse_latched == RVAG_FUSE_UNPROGRAMMED) ? RVAG_RESET_OFFSET
                                                                  : BOOT_RESET_ADDR;
  assign table_base = vector_relocate_select
                      ? RVAG_ADDR_W'(BOOT_RESET_ADDR + RVAG_TABLE_START)
                      : RVAG_TABLE_START;
  assign vector_address = rvag_vec_addr(table_base, req_index);

  // state decode
  assign in_idle = (state == RVAG_IDLE);
  assign in_hold = (state == RVAG_HOLD);
  // a live cause blocks both kinds of dispatch; the reset fetch waits until it goes away
  assign take_reset = in_idle && reset_pending && !reset_cause;
  assign take_irq = in_idle && req_any && !reset_pending && !reset_cause;
  // an interrupt fetch is dropped by a reset cause; a reset fetch stays until accepted
  assign abort_irq = in_hold && reset_cause && !fetch.is_reset;
  assign accept = in_hold && fetch_ack;
  assign clear_reset_pending = accept && fetch.is_reset;
  // offset of the winner; index 0 is kept for the reset fetch
  assign irq_number = RVAG_IDX_W'(req_index + 5'h01);

  assign reset_word = '{
    valid: 1'b1,
    is_reset: 1'b1,
    vector_index: 5'h00,
    address: reset_address
  };

  assign irq_word = '{
    valid: 1'b1,
    is_reset: 1'b0,
    vector_index: irq_number,
    address: vector_address
  };

  // external level sources pass two flops before use
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_sync1 <= 3'h0;
      pin_sync2 <= 3'h0;
    end else begin
      pin_sync1 <= {brown_out_detect, power_on_detect, ext_reset_pin};
      pin_sync2 <= pin_sync1;
    end
  end

  // fuse level comes from outside the clock domain; its synchroniser runs through reset
  always_ff @(posedge ref_clk) begin
    fuse_sync1 <= boot_reset_select_fuse;
    fuse_sync2 <= fuse_sync1;
  end

  // fuse is sampled while reset is held, so the value after release is a strap
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fuse_latched <= fuse_sync2;
    end else begin
      fuse_latched <= fuse_latched;
    end
  end

  // a reset cause is remembered until its fetch address is delivered
  // a cause in the accept cycle wins, so a second reset fetch follows
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reset_pending <= 1'b1;
    end else if (reset_cause) begin
      reset_pending <= 1'b1;
    end else if (clear_reset_pending) begin
      reset_pending <= 1'b0;
    end
  end

  // idle offers the reset fetch before any interrupt; hold waits for the accept, or for a reset cause when holding an interrupt fetch
  always_comb begin
    next_state = state;
    next_fetch = fetch;
    case (state)
      RVAG_IDLE: begin
        if (take_reset) begin
          next_fetch = reset_word;
          next_state = RVAG_HOLD;
        end else if (take_irq) begin
          next_fetch = irq_word;
          next_state = RVAG_HOLD;
        end
      end
      RVAG_HOLD: begin
        if (abort_irq || accept) begin
          next_fetch.valid = 1'b0;
          next_state = RVAG_IDLE;
        end
      end
      default: begin
        next_fetch.valid = 1'b0;
        next_state = RVAG_IDLE;
      end
    endcase
  end

  // the fetch word is a register, so the core sees no decode glitches
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= RVAG_IDLE;
      fetch <= '0;
    end else begin
      state <= next_state;
      fetch <= next_fetch;
    end
  end
endmodule

/* rvag_vector_gen_chk.sv */
// checker: fetch port timing and address relations of the vector generator
`timescale 1ns/10ps
module rvag_vector_gen_chk
  import rvag_pkg::*;
#(
  parameter logic [11:0] BOOT_RESET_ADDR = RVAG_BOOT_RESET_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic watchdog_system_reset,
  input wire logic boot_reset_select_fuse,
  input wire logic vector_relocate_select,
  input wire logic global_enable,
  input wire rvag_req_t request,
  input wire rvag_req_t request_enable,
  input wire logic fetch_ack,
  input wire rvag_fetch_t fetch
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic fuse_q;
  logic [24:0] pend_q;
  // fuse as seen during reset; pending set seen at the dispatch edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) fuse_q <= boot_reset_select_fuse;
    pend_q <= global_enable ? (request & request_enable) : 25'h0;
  end
  AST_RST_CLEAR: assert property (disable iff (1'b0) sys_rst |=> fetch == 19'h0)
    else $error("fetch not cleared by reset");
  AST_RST_FIRST: assert property ($fell(sys_rst) |=> fetch.valid && fetch.is_reset)
    else $error("no reset fetch after release");
  AST_RST_ADDR: assert property (fetch.valid && fetch.is_reset |->
    fetch.address == (fuse_q ? 12'h000 : BOOT_RESET_ADDR) && fetch.vector_index == 5'h00)
    else $error("reset address wrong");
  // vector_index carries the table offset, so the address is section start plus index
  AST_VEC_ADDR: assert property (fetch.valid && !fetch.is_reset |->
    fetch.address == (vector_relocate_select ? BOOT_RESET_ADDR : 12'h000) +
    {7'h00, fetch.vector_index})
    else $error("vector address wrong");
  // offset 1 sits in the top bit of the flattened request struct
  AST_PRIO: assert property ($rose(fetch.valid) && !fetch.is_reset |->
    pend_q[5'd25 - fetch.vector_index] && (pend_q >> (5'd26 - fetch.vector_index)) == 25'h0)
    else $error("dispatch not lowest pending vector");
  AST_HOLD: assert property (fetch.valid && !fetch_ack |=>
    fetch.valid && $stable(fetch))
    else $error("fetch changed before accept");
  AST_ACK_DROP: assert property (fetch.valid && fetch_ack |=> !fetch.valid)
    else $error("fetch stayed after accept");
  AST_CAUSE_BLOCK: assert property (watchdog_system_reset && !fetch.valid |=>
    !fetch.valid)
    else $error("fetch issued under reset cause");
endmodule
bind rvag_vector_gen rvag_vector_gen_chk #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) chk_u (.ref_clk,
  .sys_rst, .watchdog_system_reset, .boot_reset_select_fuse, .vector_relocate_select,
  .global_enable, .request, .request_enable, .fetch_ack, .fetch);

/* rvag_core_model.sv */
// partner: core fetch side that accepts each held fetch after a set delay
`timescale 1ns/10ps
module rvag_core_model
  import rvag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire rvag_fetch_t fetch,
  input wire logic [3:0] ack_delay,
  output logic fetch_ack
);
  logic [3:0] waited;
  initial fetch_ack = 1'b0;
  // accept is held until valid drops, so it is seen at exactly one edge
  always @(negedge ref_clk) begin
    if (sys_rst || !fetch.valid) begin
      waited <= 4'h0;
      fetch_ack <= 1'b0;
    end else begin
      waited <= waited + 4'h1;
      fetch_ack <= (waited >= ack_delay);
    end
  end
endmodule

/* reset_and_vector_address_generator_tb_top.sv */
// testbench: reset, vector order, masking and reset-cause scenarios
`timescale 1ns/10ps
module reset_and_vector_address_generator_tb_top
  import rvag_pkg::*;
;
  localparam logic [11:0] BOOT = 12'h700;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] cause = 4'h0;
  logic fuse = 1'b1;
  logic reloc = 1'b0;
  logic gen = 1'b1;
  rvag_req_t req = '0;
  rvag_req_t ren = '0;
  logic [3:0] dly = 4'h0;
  logic fetch_ack;
  rvag_fetch_t fetch;
  int n_errors = 0;
  int n_tests = 0;
  always #25 ref_clk = ~ref_clk;
  rvag_vector_gen #(.BOOT_RESET_ADDR(BOOT)) dut_u (.ref_clk, .sys_rst,
    .ext_reset_pin(cause[3]), .power_on_detect(cause[2]), .brown_out_detect(cause[1]),
    .watchdog_system_reset(cause[0]), .boot_reset_select_fuse(fuse),
    .vector_relocate_select(reloc), .global_enable(gen), .request(req),
    .request_enable(ren), .fetch_ack, .fetch);
  rvag_core_model core_u (.ref_clk, .sys_rst, .fetch, .ack_delay(dly), .fetch_ack);
  task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // waits for valid low, then for the next dispatch
  task get(output logic ok);
    logic lo;
    ok = 1'b0;
    lo = !fetch.valid;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(negedge ref_clk);
      if (!fetch.valid) lo = 1'b1;
      else if (lo) ok = 1'b1;
    end
  endtask
  task t_reset(input logic f);
    logic ok;
    fuse = f;
    sys_rst = 1'b1;
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    get(ok);
    chk("rst", {5'h0, ok, fetch.is_reset, fetch.vector_index}, 12'h060);
    chk("rst_addr", fetch.address, f ? 12'h000 : BOOT);
    $display("done reset");
  endtask
  // all sources raised; each is cleared once dispatched
  task t_order(input logic rl, input rvag_req_t en, input logic [3:0] d);
    logic ok;
    logic [11:0] base;
    base = rl ? BOOT : 12'h000;
    reloc = rl;
    dly = d;
    ren = en;
    req = '1;
    for (int v = 2; v <= 26; v++) begin
      if (en[26-v]) begin
        get(ok);
        // vector number v sits at table offset v - 1
        chk("vec", {5'h0, ok, fetch.is_reset, fetch.vector_index},
            12'(12'h040 + v - 1));
        chk("vec_addr", fetch.address, 12'(base + v - 1));
        req[26-v] = 1'b0;
      end
    end
    req = '0;
    $display("done order");
  endtask
  // lets a fetch still held from the previous scenario be accepted first
  task drain();
    for (int i = 0; i < 20 && fetch.valid; i++) @(negedge ref_clk);
  endtask
  task t_mask();
    gen = 1'b0;
    req = '1;
    ren = '1;
    drain();
    repeat (10) begin
      @(negedge ref_clk);
      chk("masked", {11'h0, fetch.valid}, 12'h000);
    end
    req = '0;
    gen = 1'b1;
    $display("done mask");
  endtask
  task t_cause();
    logic ok;
    for (int c = 0; c < 4; c++) begin
      drain();
      cause[c] = 1'b1;
      repeat (6) begin
        @(negedge ref_clk);
        chk("held", {11'h0, fetch.valid}, 12'h000);
      end
      cause = 4'h0;
      get(ok);
      chk("cause", {5'h0, ok, fetch.is_reset, fetch.vector_index}, 12'h060);
      chk("cause_addr", fetch.address, fuse ? 12'h000 : BOOT);
    end
    $display("done cause");
  endtask
  task complete_run();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    t_reset(1'b1);
    t_order(1'b0, '1, 4'h0);
    t_reset(1'b0);
    t_order(1'b1, 25'h0aaaaaa, 4'h2);
    t_mask();
    t_cause();
    complete_run();
  end
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
endmodule
